// ### logic/adcsc_pkg.sv
// constants and types of the converter sequence controller
package adcsc_pkg;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  localparam logic [15:0] ADCSC_BASE_BLOCKING = 16'h0200;
  localparam logic [15:0] ADCSC_BASE_NONBLOCKING = 16'h0300;
  localparam logic [7:0] ADCSC_OFS_CONFIG = 8'h80;
  localparam logic [7:0] ADCSC_OFS_STATUS = 8'h81;
  localparam logic [7:0] ADCSC_OFS_SELECT_HI = 8'h82;
  localparam logic [7:0] ADCSC_OFS_SELECT_LO = 8'h83;
  localparam logic [7:0] ADCSC_OFS_DONE_HI = 8'h84;
  localparam logic [7:0] ADCSC_OFS_RESULT_FIRST = 8'h86;
  localparam logic [7:0] ADCSC_OFS_RESULT_LAST = 8'hA5;

  // ---------------------------------------------------------------
  // field layout and reset values
  // ---------------------------------------------------------------
  localparam int ADCSC_CFG_IRQ_EN_BIT = 7;
  localparam int ADCSC_CFG_CONT_BIT = 6;
  localparam int ADCSC_CFG_OCE_BIT = 5;
  localparam int ADCSC_CFG_SRST_BIT = 4;
  localparam logic [7:0] ADCSC_CFG_WRITE_MASK = 8'hF7;
  localparam logic [7:0] ADCSC_CFG_RESET = 8'h00;
  localparam logic [3:0] ADCSC_COUNTER_RESET = 4'hF;
  localparam logic [15:0] ADCSC_SELECT_MASK = 16'hDFFF;
  localparam logic [15:0] ADCSC_SELECT_RESET = 16'h0000;
  localparam logic [3:0] ADCSC_CAL_CHANNEL = 4'hF;
  localparam logic [3:0] ADCSC_LAST_CHANNEL = 4'hE;
  localparam logic [3:0] ADCSC_FIRST_AFTER_CAL = 4'h0;
  localparam int ADCSC_CAL_NOMINAL = 8;

  // ---------------------------------------------------------------
  // converter clock cycles per phase
  // ---------------------------------------------------------------
  localparam logic [4:0] ADCSC_SAMPLE_CYCLES = 5'h09;
  localparam logic [4:0] ADCSC_CONVERT_CYCLES = 5'h12;
  localparam logic [4:0] ADCSC_GAP_CYCLES = 5'h04;

  // sequencer states, gray along idle-count-sample-convert-gap
  typedef enum logic [2:0] {
    ADCSC_IDLE = 3'h0,
    ADCSC_COUNT = 3'h1,
    ADCSC_SAMPLE = 3'h3,
    ADCSC_CONVERT = 3'h2,
    ADCSC_GAP = 3'h6
  } adcsc_state_t;

  // interface clocks per converter clock for a divider code
  function automatic logic [3:0] adcsc_divide_ratio(input logic [2:0] code);
    case (code)
      3'h0: adcsc_divide_ratio = 4'hA;
      3'h1: adcsc_divide_ratio = 4'h8;
      3'h2: adcsc_divide_ratio = 4'h6;
      3'h3: adcsc_divide_ratio = 4'h4;
      3'h4: adcsc_divide_ratio = 4'h2;
      default: adcsc_divide_ratio = 4'h1;
    endcase
  endfunction

endpackage

// ### logic/adcsc_controller.sv
// converter sequence controller: registers, prescaler, channel sequencer
//
// Overview of operation
// - soft reset bit holds converter logic and all registers but config at initial values
// - divider code 000..100 gives 10,8,6,4,2; 101..111 give 1
// - sequence done sets status bit 7; status read clears it
// - status bit 6 shows reference supply in current limitation
// - status bits 3-0 show channel in conversion; all ones after reset
// - order is channel 15, then 0 upward to 14
// - select bit includes channel; bit 13 absent, reads zero
// - select write aborts sequence; high byte write restarts with new selection
// - all-zero select write stops conversion, converter idles
// - any select write clears all per-channel done flags
// - byte write: high byte starts conversion, low byte never starts
// - done register read-only, byte read returns live status, no latch
// - reading the high byte of a result register clears that channel's done flag
// - byte result read: low latches high; high read clears flag
// - mux: 0-8 inputs, 9-12 senses, 14 bandgap, 15 calibration
// - offset compensation only with enable bit and channel 15 at start
// - calibration reference corresponds to nominal 8 LSB
// - each conversion: 9 sampling cycles then 18 conversion cycles
// - before first conversion count one cycle per position from 15
// - four converter cycles between consecutive channel conversions
// - search for next channel overlaps current conversion
// - registers decode at base 0x0200 and 0x0300
// - config bit 7 lets sequence done raise interrupt request
// - config bit 6 repeats the sequence continuously
`timescale 1ns/100ps

module adcsc_controller
  import adcsc_pkg::*;
#(
  parameter int RESULT_BITS = 10
)
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [15:0] i_address,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic i_wide,
  input wire logic [15:0] i_wdata,
  input wire logic [RESULT_BITS-1:0] i_conversion_result,
  input wire logic i_reference_current_limit,
  output logic [15:0] o_rdata,
  output logic o_read_valid,
  output logic o_sequence_irq,
  output logic o_converter_tick,
  output logic o_converter_reset,
  output logic [3:0] o_mux_channel,
  output logic o_sampling,
  output logic o_converting
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  generate
    if (RESULT_BITS < 4 || RESULT_BITS > 16)
    begin : g_bad_width
      $error("RESULT_BITS must lie between 4 and 16");
    end
  endgenerate

  localparam int PAD_BITS = 16 - RESULT_BITS;

  // next channel position in conversion order
  function automatic logic [3:0] next_position(input logic [3:0] pos);
    next_position = (pos == ADCSC_CAL_CHANNEL) ? ADCSC_FIRST_AFTER_CAL : pos + 4'h1;
  endfunction

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  logic [7:0] config_reg;
  logic [15:0] channel_select_reg;
  logic [15:0] conversion_done_reg;
  logic sequence_done_flag_reg;
  logic [3:0] channel_counter_reg;
  adcsc_state_t state_reg;
  logic [4:0] phase_count_reg;
  logic [3:0] prescale_reg;
  logic comp_active_reg;
  logic [RESULT_BITS-1:0] cal_value_reg;
  logic [RESULT_BITS-1:0] result_mem [16];
  logic [7:0] latch_high_reg;
  logic latch_valid_reg;
  logic [3:0] latch_channel_reg;

  // ---------------------------------------------------------------
  // address decode and access events
  // ---------------------------------------------------------------
  logic bus_hit;
  logic [7:0] offset;
  logic [7:0] pair_offset;
  logic is_result;
  logic [3:0] result_index;
  logic soft_reset;
  logic write_cfg;
  logic write_sel_hi;
  logic write_sel_lo;
  logic select_written;
  logic start_request;
  logic [15:0] select_next;
  logic read_status;
  logic read_result_high;
  logic read_result_low;

  assign bus_hit = (i_address[15:8] == ADCSC_BASE_BLOCKING[15:8])
                || (i_address[15:8] == ADCSC_BASE_NONBLOCKING[15:8]);
  assign offset = i_address[7:0];
  assign pair_offset = {offset[7:1], 1'b0};
  assign is_result = (offset >= ADCSC_OFS_RESULT_FIRST) && (offset <= ADCSC_OFS_RESULT_LAST);
  assign result_index = 4'((offset - ADCSC_OFS_RESULT_FIRST) >> 1);
  assign soft_reset = config_reg[ADCSC_CFG_SRST_BIT];

  // write strobes; a wide write targets the even address of a pair
  assign write_cfg = bus_hit && i_write && (pair_offset == ADCSC_OFS_CONFIG)
                  && (i_wide || offset == ADCSC_OFS_CONFIG);
  assign write_sel_hi = bus_hit && i_write && !soft_reset
                     && (offset == ADCSC_OFS_SELECT_HI);
  assign write_sel_lo = bus_hit && i_write && !soft_reset && !i_wide
                     && (offset == ADCSC_OFS_SELECT_LO);
  assign select_written = write_sel_hi || write_sel_lo;
  assign start_request = write_sel_hi;

  // merged select value, channel 13 forced to zero
  always_comb
  begin
    select_next = channel_select_reg;
    if (write_sel_hi && i_wide)
      select_next = i_wdata;
    else if (write_sel_hi)
      select_next[15:8] = i_wdata[7:0];
    else if (write_sel_lo)
      select_next[7:0] = i_wdata[7:0];
    select_next = select_next & ADCSC_SELECT_MASK;
  end

  // read events that clear flags or load the high byte latch
  assign read_status = bus_hit && i_read && (pair_offset == ADCSC_OFS_CONFIG)
                    && (i_wide || offset == ADCSC_OFS_STATUS);
  assign read_result_high = bus_hit && i_read && is_result && !offset[0];
  assign read_result_low = bus_hit && i_read && is_result && offset[0] && !i_wide;

  // ---------------------------------------------------------------
  // configuration register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      config_reg <= ADCSC_CFG_RESET;
    else if (write_cfg)
      config_reg <= (i_wide ? i_wdata[15:8] : i_wdata[7:0]) & ADCSC_CFG_WRITE_MASK;
  end

  // ---------------------------------------------------------------
  // channel select register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      channel_select_reg <= ADCSC_SELECT_RESET;
    else if (soft_reset)
      channel_select_reg <= ADCSC_SELECT_RESET;
    else if (select_written)
      channel_select_reg <= select_next;
  end

  // ---------------------------------------------------------------
  // prescaler: one converter tick every ratio interface clocks
  // ---------------------------------------------------------------
  logic [3:0] divide_ratio;
  logic converter_tick;

  assign divide_ratio = adcsc_divide_ratio(config_reg[2:0]);
  assign converter_tick = !soft_reset && (prescale_reg >= divide_ratio - 4'h1);

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      prescale_reg <= 4'h0;
    else if (soft_reset || converter_tick)
      prescale_reg <= 4'h0;
    else
      prescale_reg <= prescale_reg + 4'h1;
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  logic [3:0] following_channel;
  logic has_following;
  logic conversion_end;
  logic sequence_end;

  // search for the next selected channel in order, during conversion
  always_comb
  begin
    logic [3:0] pos;
    pos = channel_counter_reg;
    following_channel = channel_counter_reg;
    has_following = 1'b0;
    for (int step = 0; step < 15; step++)
    begin
      if (pos != ADCSC_LAST_CHANNEL && !has_following)
      begin
        pos = next_position(pos);
        if (channel_select_reg[pos])
        begin
          following_channel = pos;
          has_following = 1'b1;
        end
      end
    end
  end

  assign conversion_end = converter_tick && (state_reg == ADCSC_CONVERT)
                       && (phase_count_reg == ADCSC_CONVERT_CYCLES - 5'h01);
  assign sequence_end = conversion_end && !has_following;

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_reg <= ADCSC_IDLE;
      channel_counter_reg <= ADCSC_COUNTER_RESET;
      phase_count_reg <= 5'h00;
      comp_active_reg <= 1'b0;
    end
    else if (soft_reset)
    begin
      state_reg <= ADCSC_IDLE;
      channel_counter_reg <= ADCSC_COUNTER_RESET;
      phase_count_reg <= 5'h00;
      comp_active_reg <= 1'b0;
    end
    else if (select_written)
    begin
      // abort and restart from channel 15, or stop on zero/low byte
      channel_counter_reg <= ADCSC_CAL_CHANNEL;
      phase_count_reg <= 5'h00;
      comp_active_reg <= config_reg[ADCSC_CFG_OCE_BIT] && select_next[ADCSC_CAL_CHANNEL];
      if (start_request && select_next != ADCSC_SELECT_RESET)
        state_reg <= ADCSC_COUNT;
      else
        state_reg <= ADCSC_IDLE;
    end
    else if (converter_tick)
    begin
      case (state_reg)
        ADCSC_COUNT:
        begin
          // one cycle per position until a selected channel is met
          if (channel_select_reg[channel_counter_reg])
            state_reg <= ADCSC_SAMPLE;
          else
            channel_counter_reg <= next_position(channel_counter_reg);
        end
        ADCSC_SAMPLE:
        begin
          if (phase_count_reg == ADCSC_SAMPLE_CYCLES - 5'h01)
          begin
            state_reg <= ADCSC_CONVERT;
            phase_count_reg <= 5'h00;
          end
          else
            phase_count_reg <= phase_count_reg + 5'h01;
        end
        ADCSC_CONVERT:
        begin
          phase_count_reg <= 5'h00;
          if (conversion_end && has_following)
            state_reg <= ADCSC_GAP;
          else if (conversion_end && config_reg[ADCSC_CFG_CONT_BIT])
          begin
            state_reg <= ADCSC_COUNT;
            channel_counter_reg <= ADCSC_CAL_CHANNEL;
          end
          else if (conversion_end)
            state_reg <= ADCSC_IDLE;
          else
            phase_count_reg <= phase_count_reg + 5'h01;
        end
        ADCSC_GAP:
        begin
          if (phase_count_reg == ADCSC_GAP_CYCLES - 5'h01)
          begin
            state_reg <= ADCSC_SAMPLE;
            channel_counter_reg <= following_channel;
            phase_count_reg <= 5'h00;
          end
          else
            phase_count_reg <= phase_count_reg + 5'h01;
        end
        default:
          state_reg <= state_reg;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // result capture with offset compensation
  // ---------------------------------------------------------------
  logic signed [RESULT_BITS+1:0] corrected;
  logic [RESULT_BITS-1:0] stored_value;

  // raw + nominal - calibration reading, clamped to the result range
  always_comb
  begin
    corrected = $signed({2'b00, i_conversion_result})
              + $signed((RESULT_BITS+2)'(ADCSC_CAL_NOMINAL))
              - $signed({2'b00, cal_value_reg});
    if (!comp_active_reg || channel_counter_reg == ADCSC_CAL_CHANNEL)
      stored_value = i_conversion_result;
    else if (corrected < 0)
      stored_value = '0;
    else if (corrected[RESULT_BITS])
      stored_value = '1;
    else
      stored_value = corrected[RESULT_BITS-1:0];
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      cal_value_reg <= (RESULT_BITS)'(ADCSC_CAL_NOMINAL);
    else if (soft_reset)
      cal_value_reg <= (RESULT_BITS)'(ADCSC_CAL_NOMINAL);
    else if (conversion_end && channel_counter_reg == ADCSC_CAL_CHANNEL)
      cal_value_reg <= i_conversion_result;
  end

  // result storage, one word per channel
  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      for (int ch = 0; ch < 16; ch++)
        result_mem[ch] <= '0;
    end
    else if (soft_reset)
    begin
      for (int ch = 0; ch < 16; ch++)
        result_mem[ch] <= '0;
    end
    else if (conversion_end)
      result_mem[channel_counter_reg] <= stored_value;
  end

  // ---------------------------------------------------------------
  // done flags; a set in the same cycle as a clear wins
  // ---------------------------------------------------------------
  logic [15:0] done_set;
  logic [15:0] done_clear;

  assign done_set = conversion_end ? (16'h0001 << channel_counter_reg) : 16'h0000;
  assign done_clear = select_written ? 16'hFFFF
                    : (read_result_high ? (16'h0001 << result_index) : 16'h0000);

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      conversion_done_reg <= 16'h0000;
    else if (soft_reset)
      conversion_done_reg <= 16'h0000;
    else
      conversion_done_reg <= (conversion_done_reg & ~done_clear) | done_set;
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
      sequence_done_flag_reg <= 1'b0;
    else if (soft_reset)
      sequence_done_flag_reg <= 1'b0;
    else if (sequence_end)
      sequence_done_flag_reg <= 1'b1;
    else if (read_status)
      sequence_done_flag_reg <= 1'b0;
  end

  // ---------------------------------------------------------------
  // high byte latch for byte-wide result reads
  // ---------------------------------------------------------------
  logic [15:0] result_word;

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      latch_high_reg <= 8'h00;
      latch_valid_reg <= 1'b0;
      latch_channel_reg <= 4'h0;
    end
    else if (soft_reset)
    begin
      latch_high_reg <= 8'h00;
      latch_valid_reg <= 1'b0;
      latch_channel_reg <= 4'h0;
    end
    else if (read_result_low)
    begin
      latch_high_reg <= result_word[15:8];
      latch_valid_reg <= 1'b1;
      latch_channel_reg <= result_index;
    end
    else if (read_result_high)
      latch_valid_reg <= 1'b0;
  end

  // ---------------------------------------------------------------
  // read data path
  // ---------------------------------------------------------------
  logic [15:0] pair_word;
  logic [7:0] status_byte;
  logic [7:0] high_byte;

  assign result_word = {result_mem[result_index], PAD_BITS'(0)};
  assign status_byte = {sequence_done_flag_reg, i_reference_current_limit,
                        2'b00, channel_counter_reg};

  always_comb
  begin
    if (pair_offset == ADCSC_OFS_CONFIG)
      pair_word = {config_reg, status_byte};
    else if (pair_offset == ADCSC_OFS_SELECT_HI)
      pair_word = channel_select_reg;
    else if (pair_offset == ADCSC_OFS_DONE_HI)
      pair_word = conversion_done_reg;
    else if (is_result)
      pair_word = result_word;
    else
      pair_word = 16'h0000;
  end

  // high byte of a result comes from the latch after a low byte read
  assign high_byte = (is_result && latch_valid_reg && latch_channel_reg == result_index)
                   ? latch_high_reg : pair_word[15:8];

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_rdata <= 16'h0000;
      o_read_valid <= 1'b0;
    end
    else
    begin
      o_read_valid <= i_read;
      if (!bus_hit || !i_read)
        o_rdata <= 16'h0000;
      else if (i_wide)
        o_rdata <= pair_word;
      else if (offset[0])
        o_rdata <= {8'h00, pair_word[7:0]};
      else
        o_rdata <= {8'h00, high_byte};
    end
  end

  // ---------------------------------------------------------------
  // interrupt request and outputs to the analog side
  // ---------------------------------------------------------------
  assign o_sequence_irq = sequence_done_flag_reg && config_reg[ADCSC_CFG_IRQ_EN_BIT];
  assign o_converter_tick = converter_tick;
  assign o_converter_reset = soft_reset;
  assign o_mux_channel = channel_counter_reg;
  assign o_sampling = (state_reg == ADCSC_SAMPLE);
  assign o_converting = (state_reg == ADCSC_CONVERT);

endmodule // adcsc_controller

// ### testbench/adcsc_chk.sv
// port assertions for the converter sequence controller
`timescale 1ns/100ps
module adcsc_chk
#(
  parameter int RESULT_BITS = 10
)
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [15:0] i_address,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic i_wide,
  input wire logic [15:0] i_wdata,
  input wire logic [RESULT_BITS-1:0] i_conversion_result,
  input wire logic i_reference_current_limit,
  input wire logic [15:0] o_rdata,
  input wire logic o_read_valid,
  input wire logic o_sequence_irq,
  input wire logic o_converter_tick,
  input wire logic o_converter_reset,
  input wire logic [3:0] o_mux_channel,
  input wire logic o_sampling,
  input wire logic o_converting
);
  logic [4:0] samp_cnt;
  logic [4:0] conv_cnt;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  // converter ticks seen while sampling
  always_ff @(posedge i_clock or posedge i_reset)
    if (i_reset)
      samp_cnt <= 5'h00;
    else
      samp_cnt <= o_sampling ? samp_cnt + 5'(o_converter_tick) : 5'h00;
  // converter ticks seen while converting
  always_ff @(posedge i_clock or posedge i_reset)
    if (i_reset)
      conv_cnt <= 5'h00;
    else
      conv_cnt <= o_converting ? conv_cnt + 5'(o_converter_tick) : 5'h00;
  a_read_answer:
    assert property (i_read |=> o_read_valid) else $error("read not answered");
  a_idle_bus_quiet:
    assert property (!i_read |=> !o_read_valid && o_rdata == 16'h0000)
    else $error("read data outside a read");
  a_soft_reset_hold:
    assert property (o_converter_reset && $past(o_converter_reset)
      |-> o_mux_channel == 4'hF && !o_sampling && !o_converting) else $error("soft reset leak");
  a_sample_len:
    assert property ($fell(o_sampling) && o_converting |-> samp_cnt == 5'h09)
    else $error("sampling length wrong");
  a_convert_len:
    assert property ($fell(o_converting) && !$past(i_write) && !o_converter_reset
      |-> conv_cnt == 5'h12)
    else $error("conversion length wrong");
  a_phase_exclusive:
    assert property (!(o_sampling && o_converting)) else $error("phases overlap");
  a_no_channel13:
    assert property (o_sampling || o_converting |-> o_mux_channel != 4'hD)
    else $error("missing channel converted");
  a_tick_spacing:
    assert property (o_converter_tick && !o_converter_reset
      |-> ##[1:10] (o_converter_tick || o_converter_reset)) else $error("tick too late");
  a_status_clears:
    assert property (i_read && !i_wide && i_address[15:9] == 7'h01
      && i_address[7:0] == 8'h81 && !o_converting |=> !o_sequence_irq)
    else $error("done flag survives status read");
  a_select_restart:
    assert property (i_write && i_wide && i_address[15:9] == 7'h01
      && i_address[7:0] == 8'h82 |=> !o_sampling && !o_converting)
    else $error("select write did not restart");
endmodule // adcsc_chk

bind adcsc_controller adcsc_chk #(.RESULT_BITS(RESULT_BITS)) u_chk (.i_clock(i_clock),
  .i_reset(i_reset), .i_address(i_address), .i_write(i_write), .i_read(i_read),
  .i_wide(i_wide), .i_wdata(i_wdata), .i_conversion_result(i_conversion_result),
  .i_reference_current_limit(i_reference_current_limit), .o_rdata(o_rdata),
  .o_read_valid(o_read_valid), .o_sequence_irq(o_sequence_irq),
  .o_converter_tick(o_converter_tick), .o_converter_reset(o_converter_reset),
  .o_mux_channel(o_mux_channel), .o_sampling(o_sampling), .o_converting(o_converting));

// ### testbench/adcsc_host.sv
// host bus master model driving the converter registers
`timescale 1ns/100ps
module adcsc_host
(
  input wire logic i_clock,
  output logic [15:0] o_address,
  output logic o_write,
  output logic o_read,
  output logic o_wide,
  output logic [15:0] o_wdata
);
  // bus idle at time zero
  initial
  begin
    o_address = 16'h0000;
    o_write = 1'b0;
    o_read = 1'b0;
    o_wide = 1'b1;
    o_wdata = 16'h0000;
  end
  // one access: strobe held one clock, taken at the rising edge, then released
  task automatic access(input logic [15:0] addr, input logic [15:0] data, input logic wide,
    input logic is_write);
    @(negedge i_clock);
    o_address <= addr;
    o_wdata <= is_write ? data : ~o_wdata;
    o_wide <= wide;
    o_write <= is_write;
    o_read <= !is_write;
    @(negedge i_clock);
    o_write <= 1'b0;
    o_read <= 1'b0;
    o_address <= ~addr; // released lines never repeat the last value
    o_wdata <= ~data;
  endtask
endmodule // adcsc_host

// ### testbench/adc_sequence_controller_test.sv
// self-checking bench for the converter sequence controller
`timescale 1ns/100ps
module adc_sequence_controller_test;
  logic clock, reset, write, read, wide, rvalid, irq, tick, conv_rst, sampling, converting;
  logic cur_limit;
  logic [15:0] addr, wdata, rdata;
  logic [9:0] raw;
  logic [3:0] mux;
  logic [31:0] exp_q[$];
  logic [3:0] ord_q[$];
  logic [31:0] ent;
  logic prev_samp = 1'b0;
  int fail_count = 0;
  int checks = 0;
  int seed = 87;
  int cycles = 0;
  int ratio[8] = '{10, 8, 6, 4, 2, 1, 1, 1};
  int n;
  // free running clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  adcsc_host host (.i_clock(clock), .o_address(addr), .o_write(write), .o_read(read),
    .o_wide(wide), .o_wdata(wdata));
  adcsc_controller #(.RESULT_BITS(10)) dut (.i_clock(clock), .i_reset(reset),
    .i_address(addr), .i_write(write), .i_read(read), .i_wide(wide), .i_wdata(wdata),
    .i_conversion_result(raw), .i_reference_current_limit(cur_limit), .o_rdata(rdata),
    .o_read_valid(rvalid), .o_sequence_irq(irq), .o_converter_tick(tick),
    .o_converter_reset(conv_rst), .o_mux_channel(mux), .o_sampling(sampling),
    .o_converting(converting));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // writes use the blocking base, reads the non-blocking one
  task automatic wr(input logic [7:0] ofs, input logic [15:0] data, input logic w);
    host.access({8'h02, ofs}, data, w, 1'b1);
  endtask
  task automatic rd(input logic [7:0] ofs, input logic w, input logic [15:0] m,
    input logic [15:0] want);
    exp_q.push_back({m, want});
    host.access({8'h03, ofs}, 16'h0000, w, 1'b0);
  endtask
  // start a sequence, time it up to the done interrupt, then clear the flag
  task automatic run(input logic [15:0] sel, input logic w, input int want);
    raw = 10'($random(seed));
    wr(8'h82, sel, w);
    n = 0;
    while (irq !== 1'b1 && n < 1000)
    begin
      @(negedge clock);
      n++;
    end
    check("sequence time", 16'(n >= want - 2 && n <= want + 1), 16'h0001);
    rd(8'h81, 1'b0, 16'h00F0, 16'h0080);
  endtask
  task automatic watch(input int len, input logic want);
    logic seen;
    seen = 1'b0;
    repeat (len)
    begin
      @(negedge clock);
      seen = seen | (sampling === 1'b1);
    end
    check("sampling seen", {15'h0000, seen}, {15'h0000, want});
  endtask
  // read results, channel order and timeout
  always @(negedge clock)
  begin
    cycles <= cycles + 1;
    if (rvalid === 1'b1 && exp_q.size() == 0)
      check("read valid", 16'h0001, 16'h0000);
    else if (rvalid === 1'b1)
    begin
      ent = exp_q.pop_front();
      check("rdata", rdata & ent[31:16], ent[15:0]);
    end
    if (sampling === 1'b1 && !prev_samp && ord_q.size() > 0)
      check("channel", {12'h000, mux}, {12'h000, ord_q.pop_front()});
    prev_samp <= (sampling === 1'b1);
    if (cycles == 20000)
    begin
      fail_count++;
      give_verdict();
    end
  end
  // main sequence
  initial
  begin
    reset = 1'b1;
    raw = 10'h000;
    cur_limit = 1'b0;
    repeat (12) @(negedge clock);
    reset = 1'b0;
    rd(8'h81, 1'b0, 16'hFFFF, 16'h000F);
    rd(8'h82, 1'b1, 16'hFFFF, 16'h0000);
    rd(8'hA0, 1'b0, 16'hFFFF, 16'h0000);
    exp_q.push_back(32'hFFFF0000);
    host.access(16'h0481, 16'h0000, 1'b0, 1'b0);
    cur_limit = 1'b1;
    rd(8'h81, 1'b0, 16'hFFFF, 16'h004F);
    cur_limit = 1'b0;
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h80, 16'(c), 1'b0);
      do @(negedge clock); while (tick !== 1'b1);
      n = 0;
      do
      begin
        @(negedge clock);
        n++;
      end
      while (tick !== 1'b1 && n < 20);
      check("tick spacing", n[15:0], ratio[c][15:0]);
    end
    wr(8'h80, 16'h00A5, 1'b0);
    run(16'h0400, 1'b1, 39);
    rd(8'h9A, 1'b1, 16'hFFFF, {raw, 6'h00});
    run(16'h0400, 1'b1, 39);
    wr(8'h83, 16'h0001, 1'b0);
    rd(8'h84, 1'b1, 16'hFFFF, 16'h0000);
    watch(100, 1'b0);
    run(16'h0084, 1'b0, 90);
    rd(8'h84, 1'b0, 16'hFFFF, 16'h0084);
    rd(8'h85, 1'b0, 16'hFFFF, 16'h0001);
    rd(8'h86, 1'b1, 16'hFFFF, 16'h0200);
    rd(8'h9B, 1'b0, 16'hFFFF, 16'h0000);
    rd(8'h84, 1'b0, 16'hFFFF, 16'h0084);
    rd(8'h9A, 1'b0, 16'hFFFF, 16'h0002);
    rd(8'h84, 1'b0, 16'hFFFF, 16'h0080);
    rd(8'hA4, 1'b1, 16'hFFFF, {raw, 6'h00});
    rd(8'h84, 1'b1, 16'hFFFF, 16'h0000);
    wr(8'h82, 16'h8000, 1'b1);
    repeat (10) @(negedge clock);
    wr(8'h82, 16'h0000, 1'b1);
    watch(100, 1'b0);
    wr(8'h82, 16'h0400, 1'b1);
    ord_q.push_back(4'hF);
    for (int k = 0; k < 15; k++)
      if (k != 13)
        ord_q.push_back(4'(k));
    run(16'hFFFF, 1'b1, 462);
    rd(8'h82, 1'b1, 16'hFFFF, 16'hDFFF);
    wr(8'h82, 16'h8000, 1'b1);
    repeat (5) @(negedge clock);
    wr(8'h80, 16'h0095, 1'b0);
    rd(8'h81, 1'b0, 16'hFFFF, 16'h000F);
    rd(8'h84, 1'b1, 16'hFFFF, 16'h0000);
    wr(8'h82, 16'h0400, 1'b1);
    rd(8'h82, 1'b1, 16'hFFFF, 16'h0000);
    watch(50, 1'b0);
    wr(8'h80, 16'h00CD, 1'b0);
    rd(8'h80, 1'b0, 16'hFFFF, 16'h00C5);
    run(16'h8000, 1'b1, 28);
    watch(60, 1'b1);
    wr(8'h80, 16'h0085, 1'b0);
    repeat (60) @(negedge clock);
    watch(100, 1'b0);
    give_verdict();
  end
endmodule // adc_sequence_controller_test
